// *** rtl/sme_defines.svh ***
// Offsets, field positions, reset values and widths for the shift/move/indirect datapath.
// Assumes inclusion by bare name from the package and the datapath module.
`ifndef SME_DEFINES_SVH
`define SME_DEFINES_SVH
// Register byte offsets on the Avalon-MM slave
`define SME_CTRL_OFS    8'h00
`define SME_STATUS_OFS  8'h04
`define SME_WREG_OFS    8'h08
`define SME_PTR0_OFS    8'h0c
`define SME_PTR1_OFS    8'h10
// Field positions
`define SME_CTRL_EN_BIT   0
`define SME_STAT_C_BIT    0
`define SME_STAT_Z_BIT    1
// Reset values
`define SME_CTRL_RST    1'b1
`define SME_PTR_RST     16'h0000
`define SME_W_RST       8'h00
// Widths and counts
`define SME_PTR_W       16
`define SME_NUM_PTR     2
`define SME_FADDR_W     7
`define SME_OFS_W       6
`endif

// *** rtl/sme_pkg.sv ***
// Types shared by the shift/move/indirect datapath and its surroundings.
// Assumes the defines header is on the include path.
`include "sme_defines.svh"
package sme_pkg;
  // Operation selected by the decoder
  typedef enum logic [2:0] {
    SME_NOP,
    SME_SHL,
    SME_SHR,
    SME_MOV,
    SME_IND
  } sme_op_t;

  // Pointer update mode of the indirect load
  typedef enum logic [1:0] {
    SME_PRE_INC  = 2'h0,
    SME_PRE_DEC  = 2'h1,
    SME_POST_INC = 2'h2,
    SME_POST_DEC = 2'h3
  } sme_mode_t;

  // One decoded instruction
  typedef struct packed {
    sme_op_t                  op;
    logic [`SME_FADDR_W-1:0]  f_addr;
    logic                     dest;
    logic                     ptr_sel;
    sme_mode_t                pointer_update_mode;
    logic                     indexed;
    logic [`SME_OFS_W-1:0]    offset;
  } sme_cmd_t;
endpackage

// *** rtl/sme_exec.sv ***
// Execution datapath: logical shifts, file move and indirect load, with an Avalon-MM slave.
// Assumes decoder and file memory on clk; file and data memory reads return in the same cycle.
// Function
// - Left shift: bit7 to carry, rest up
// - Left shift puts zero in bit0
// - Right shift: bit0 to carry, rest down
// - Right shift puts zero in bit7
// - Shift destination bit picks file or W
// - Move copies file register to W/file
// - Move updates zero flag from value
// - Indexed load adds signed offset -32..31
// - Two pointers, pre/post inc/dec forms
// - Mode encoding 00,01,10,11 as listed
// - Indirect load writes W, updates zero
// - Pointer wraps at 16 bits
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "sme_defines.svh"
module sme_exec
  import sme_pkg::*;
#(
  parameter int PTR_W = `SME_PTR_W
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire sme_cmd_t                cmd,
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  output logic [`SME_FADDR_W-1:0]      file_raddr,
  input  wire logic [7:0]              file_rdata,
  output logic                         file_we,
  output logic [`SME_FADDR_W-1:0]      file_waddr,
  output logic [7:0]                   file_wdata,
  output logic [PTR_W-1:0]             mem_addr,
  input  wire logic [7:0]              mem_rdata,
  output logic [7:0]                   w_out,
  output logic                         carry_out,
  output logic                         zero_out,
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest
);

  // Effective address of the indirect load
  function automatic logic [PTR_W-1:0] ind_addr(input logic [PTR_W-1:0] p,
                                                input sme_mode_t m, input logic idx,
                                                input logic [`SME_OFS_W-1:0] k);
    logic [PTR_W-1:0] a;
    a = p;
    if (idx) begin
      a = p + {{(PTR_W-`SME_OFS_W){k[`SME_OFS_W-1]}}, k};
    end else if (m == SME_PRE_INC) begin
      a = p + 1'b1;
    end else if (m == SME_PRE_DEC) begin
      a = p - 1'b1;
    end
    return a;
  endfunction

  // Pointer value after the indirect load; wraps naturally at PTR_W bits
  function automatic logic [PTR_W-1:0] ind_next(input logic [PTR_W-1:0] p,
                                                input sme_mode_t m, input logic idx);
    logic [PTR_W-1:0] n;
    n = p;
    if (!idx) begin
      n = (m == SME_PRE_INC || m == SME_POST_INC) ? p + 1'b1 : p - 1'b1;
    end
    return n;
  endfunction

  // Byte-lane merge of a bus write into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic                    ctrl_en_q;
  logic                    ctrl_en_d;
  logic [7:0]              w_q;
  logic [7:0]              w_d;
  logic                    carry_q;
  logic                    carry_d;
  logic                    zero_q;
  logic                    zero_d;
  logic                    fwe_q;
  logic [`SME_FADDR_W-1:0] fwaddr_q;
  logic [7:0]              fwdata_q;
  logic [PTR_W-1:0]        ptr_q [`SME_NUM_PTR];
  logic [PTR_W-1:0]        ptr_d [`SME_NUM_PTR];
  logic                    ack_q;
  logic [31:0]             rdata_q;

  // Instruction side decode
  wire              take     = cmd_valid & cmd_ready;
  wire              is_shl   = take & (cmd.op == SME_SHL);
  wire              is_shr   = take & (cmd.op == SME_SHR);
  wire              is_mov   = take & (cmd.op == SME_MOV);
  wire              is_ind   = take & (cmd.op == SME_IND);
  wire              is_file  = is_shl | is_shr | is_mov;
  wire [7:0]        shl_res  = {file_rdata[6:0], 1'b0};
  wire [7:0]        shr_res  = {1'b0, file_rdata[7:1]};
  wire [PTR_W-1:0]  cur_ptr  = ptr_q[cmd.ptr_sel];
  wire [7:0]        result   = is_shl ? shl_res :
                               is_shr ? shr_res :
                               is_ind ? mem_rdata : file_rdata;
  wire              res_zero = (result == 8'h00);

  assign cmd_ready  = ctrl_en_q;
  assign file_raddr = cmd.f_addr;
  // Pointer mode decode
  assign mem_addr   = ind_addr(cur_ptr, cmd.pointer_update_mode, cmd.indexed, cmd.offset);

  // Destination select: d=0 to W, d=1 back to file; indirect load always to W
  assign w_d     = ((is_file & ~cmd.dest) | is_ind) ? result : w_q;
  // Carry only moves on shifts
  assign carry_d = is_shl ? file_rdata[7] :
                   is_shr ? file_rdata[0] : carry_q;
  // Zero follows every executed result
  assign zero_d  = (is_file | is_ind) ? res_zero : zero_q;

  // Bus slave: one wait cycle, then the answer
  wire        req      = avs_read | avs_write;
  wire        done     = req & ack_q;
  wire        bus_wr   = avs_write & done;
  wire        hit_ctrl = (avs_address == `SME_CTRL_OFS);
  wire        hit_stat = (avs_address == `SME_STATUS_OFS);
  wire        hit_w    = (avs_address == `SME_WREG_OFS);
  wire        hit_p0   = (avs_address == `SME_PTR0_OFS);
  wire        hit_p1   = (avs_address == `SME_PTR1_OFS);
  wire [31:0] p0_word  = {{(32-PTR_W){1'b0}}, ptr_q[0]};
  wire [31:0] p1_word  = {{(32-PTR_W){1'b0}}, ptr_q[1]};
  wire [31:0] st_word  = {30'h0, zero_q, carry_q};
  wire [31:0] rd_mux   = hit_ctrl ? {31'h0, ctrl_en_q} :
                         hit_stat ? st_word :
                         hit_w    ? {24'h0, w_q} :
                         hit_p0   ? p0_word :
                         hit_p1   ? p1_word : 32'h0;   // Unmapped reads zero
  wire [31:0] ctrl_new = be_merge({31'h0, ctrl_en_q}, avs_writedata, avs_byteenable);

  assign ctrl_en_d       = (bus_wr & hit_ctrl) ? ctrl_new[`SME_CTRL_EN_BIT] : ctrl_en_q;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  // Pointer next state; an executing load beats a same-cycle bus write so no step is lost
  for (genvar i = 0; i < `SME_NUM_PTR; i++) begin : g_ptr
    wire        own_ind = is_ind & (cmd.ptr_sel == i[0]);
    wire        own_wr  = bus_wr & ((i == 0) ? hit_p0 : hit_p1);
    wire [31:0] merged  = be_merge({{(32-PTR_W){1'b0}}, ptr_q[i]}, avs_writedata,
                                   avs_byteenable);
    assign ptr_d[i] = own_ind ? ind_next(ptr_q[i], cmd.pointer_update_mode, cmd.indexed) :
                      own_wr  ? merged[PTR_W-1:0] : ptr_q[i];

    always_ff @(posedge clk) begin
      if (rst) begin
        ptr_q[i] <= PTR_W'(`SME_PTR_RST);
      end else begin
        ptr_q[i] <= ptr_d[i];
      end
    end
  end

  // Core state
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_en_q <= `SME_CTRL_RST;
      w_q       <= `SME_W_RST;
      carry_q   <= 1'b0;
      zero_q    <= 1'b0;
    end else begin
      ctrl_en_q <= ctrl_en_d;
      w_q       <= w_d;
      carry_q   <= carry_d;
      zero_q    <= zero_d;
    end
  end

  // File write-back, one cycle after the instruction is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      fwe_q    <= 1'b0;
      fwaddr_q <= '0;
      fwdata_q <= 8'h00;
    end else begin
      fwe_q    <= is_file & cmd.dest;
      fwaddr_q <= cmd.f_addr;
      fwdata_q <= result;
    end
  end

  // Bus answer; read data is caught in the wait cycle and stands through the answer
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q   <= req & ~ack_q;
      rdata_q <= (avs_read & ~ack_q) ? rd_mux : rdata_q;
    end
  end

  assign file_we    = fwe_q;
  assign file_waddr = fwaddr_q;
  assign file_wdata = fwdata_q;
  assign w_out      = w_q;
  assign carry_out  = carry_q;
  assign zero_out   = zero_q;

  // Checks next to the datapath
  chk_shl_carry_out: assert property (@(posedge clk) disable iff (rst)
    is_shl |=> carry_out == $past(file_rdata[7]))
    else $error("left shift carry wrong");

  chk_shl_w_result: assert property (@(posedge clk) disable iff (rst)
    is_shl && !cmd.dest |=> w_out == {$past(file_rdata[6:0]), 1'b0})
    else $error("left shift result wrong");

  chk_shr_carry_out: assert property (@(posedge clk) disable iff (rst)
    is_shr |=> carry_out == $past(file_rdata[0]))
    else $error("right shift carry wrong");

  chk_shr_file_write: assert property (@(posedge clk) disable iff (rst)
    is_shr && cmd.dest |=> file_we && file_wdata == {1'b0, $past(file_rdata[7:1])})
    else $error("right shift write-back wrong");

  chk_dest_file_keep: assert property (@(posedge clk) disable iff (rst)
    is_file && cmd.dest |=> file_waddr == $past(cmd.f_addr) && $stable(w_out))
    else $error("file destination disturbed W");

  chk_mov_w_copy: assert property (@(posedge clk) disable iff (rst)
    is_mov && !cmd.dest |=> w_out == $past(file_rdata) && !file_we)
    else $error("move to W wrong");

  chk_mov_zero_flag: assert property (@(posedge clk) disable iff (rst)
    is_mov |=> zero_out == ($past(file_rdata) == 8'h00))
    else $error("move zero flag wrong");

  chk_ind_index_addr: assert property (@(posedge clk) disable iff (rst)
    is_ind && cmd.indexed |-> mem_addr == cur_ptr + {{(PTR_W-6){cmd.offset[5]}}, cmd.offset}
    ##1 ptr_q[$past(cmd.ptr_sel)] == $past(cur_ptr))
    else $error("indexed load address wrong");

  chk_ind_post_inc: assert property (@(posedge clk) disable iff (rst)
    is_ind && !cmd.indexed && cmd.pointer_update_mode == 2'h2 |-> mem_addr == cur_ptr
    ##1 ptr_q[$past(cmd.ptr_sel)] == PTR_W'($past(cur_ptr) + 1'b1))
    else $error("post-increment wrong");

  chk_ind_pre_dec: assert property (@(posedge clk) disable iff (rst)
    is_ind && !cmd.indexed && cmd.pointer_update_mode == 2'h1
    |-> mem_addr == PTR_W'(cur_ptr - 1'b1))
    else $error("pre-decrement address wrong");

  chk_ind_load_w: assert property (@(posedge clk) disable iff (rst)
    is_ind |=> w_out == $past(mem_rdata) && zero_out == ($past(mem_rdata) == 8'h00))
    else $error("indirect load result wrong");

  chk_ptr_wrap_top: assert property (@(posedge clk) disable iff (rst)
    is_ind && !cmd.indexed && cur_ptr == {PTR_W{1'b1}} && cmd.pointer_update_mode == SME_PRE_INC
    |-> mem_addr == '0 ##1 ptr_q[$past(cmd.ptr_sel)] == '0)
    else $error("pointer wrap wrong");

  chk_carry_kept: assert property (@(posedge clk) disable iff (rst)
    (is_mov || is_ind) |=> $stable(carry_out))
    else $error("carry changed by non-shift");

  chk_mov_one_cycle: assert property (@(posedge clk) disable iff (rst)
    is_mov && cmd.dest |=> file_we && file_wdata == $past(file_rdata)
    ##1 (!file_we || $past(is_file && cmd.dest)))
    else $error("move write-back not single cycle");

  chk_bus_answer: assert property (@(posedge clk) disable iff (rst)
    avs_waitrequest |=> !req || !avs_waitrequest)
    else $error("bus answer late");
endmodule

// *** sim/sme_mem_model.sv ***
// File register and data memory model facing the datapath.
// Assumes same-cycle reads and a file write landing at the edge after file_we.
`timescale 1ns/100ps
module sme_mem_model (
  input  wire logic        clk,
  input  wire logic [6:0]  file_raddr,
  output logic      [7:0]  file_rdata,
  input  wire logic        file_we,
  input  wire logic [6:0]  file_waddr,
  input  wire logic [7:0]  file_wdata,
  input  wire logic [15:0] mem_addr,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] regs [0:127];

  // No forwarding: a write is seen only from the next cycle on
  assign file_rdata = regs[file_raddr];
  // Data memory content follows the address, so a wrong address shows in W
  assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8];

  // File write port
  always @(posedge clk) begin
    if (file_we) begin
      regs[file_waddr] <= file_wdata;
    end
  end
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the shift/move/indirect datapath.
// Assumes the memory model beside it and one wait state on the register bus.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import sme_pkg::*;
  logic clk = 0, rst = 1, cmd_valid = 0, cmd_ready, file_we, carry_out, zero_out;
  logic avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [6:0]  file_raddr, file_waddr;
  logic [7:0]  file_rdata, file_wdata, mem_rdata, w_out, avs_address = 0;
  logic [15:0] mem_addr;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  sme_cmd_t    cmd = '0;
  int n_fail = 0, total_checks = 0, cyc = 0;
  logic [15:0] starts [4] = '{16'hffff, 16'h0000, 16'h1234, 16'h0000};
  logic [15:0] ea, np;

  sme_exec uut (.clk(clk), .rst(rst), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .w_out(w_out), .carry_out(carry_out), .zero_out(zero_out),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  sme_mem_model u_mem (.clk(clk), .file_raddr(file_raddr), .file_rdata(file_rdata),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  initial begin
    forever #20 clk = ~clk;
  end

  // Cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report();
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Avalon-MM access: hold until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask

  // One instruction, results sampled mid-cycle after the taking edge
  task automatic issue(input sme_op_t op, input logic [6:0] f, input logic d,
                       input logic ps, input logic [1:0] m, input logic idx,
                       input logic [5:0] k);
    @(posedge clk);
    cmd <= '{op, f, d, ps, sme_mode_t'(m), idx, k};
    cmd_valid <= 1;
    @(posedge clk);
    cmd_valid <= 0;
    @(negedge clk);
  endtask

  initial begin
    u_mem.regs[5] = 8'h81;
    u_mem.regs[6] = 8'h80;
    u_mem.regs[7] = 8'h01;
    u_mem.regs[8] = 8'hfe;
    u_mem.regs[9] = 8'h00;
    u_mem.regs[10] = 8'h5a;
    repeat (8) @(posedge clk);
    rst <= 0;
    // Shifts to W and back to the file register
    issue(SME_SHL, 7'h05, 0, 0, 0, 0, 0);
    `CHK("shl w", 8'h02, w_out)
    `CHK("shl c", 1'b1, carry_out)
    `CHK("shl we", 1'b0, file_we)
    issue(SME_SHL, 7'h06, 1, 0, 0, 0, 0);
    `CHK("shl f", {1'b1, 7'h06, 8'h00}, {file_we, file_waddr, file_wdata})
    `CHK("shl z", 1'b1, zero_out)
    issue(SME_SHR, 7'h08, 1, 0, 0, 0, 0);
    `CHK("shr f", {1'b1, 7'h08, 8'h7f}, {file_we, file_waddr, file_wdata})
    `CHK("shr cz", 2'b00, {carry_out, zero_out})
    issue(SME_SHR, 7'h07, 0, 0, 0, 0, 0);
    `CHK("shr w", 8'h00, w_out)
    `CHK("shr cz", 2'b11, {carry_out, zero_out})
    // Moves keep carry; two moves with an idle cycle between, single-cycle results
    issue(SME_MOV, 7'h0a, 0, 0, 0, 0, 0);
    `CHK("mov w", 8'h5a, w_out)
    `CHK("mov cz", 2'b10, {carry_out, zero_out})
    issue(SME_MOV, 7'h09, 1, 0, 0, 0, 0);
    `CHK("mov f", {1'b1, 7'h09, 8'h00}, {file_we, file_waddr, file_wdata})
    `CHK("mov wz", {8'h5a, 1'b1}, {w_out, zero_out})
    bus(0, 8'h04, 0);
    `CHK("status", 32'h3, rd)
    // All four pointer modes; all but post-increment (from 1234) cross the wrap point
    for (int m = 0; m < 4; m++) begin
      bus(1, 8'h0c, {16'h0, starts[m]});
      np = m[0] ? starts[m] - 16'h1 : starts[m] + 16'h1;
      ea = m[1] ? starts[m] : np;
      issue(SME_IND, 7'h00, 0, 0, m[1:0], 0, 0);
      `CHK("ind w", ea[7:0] ^ ea[15:8], w_out)
      `CHK("ind z", (ea[7:0] ^ ea[15:8]) == 8'h00, zero_out)
      bus(0, 8'h0c, 0);
      `CHK("ind ptr", {16'h0, np}, rd)
    end
    // Indexed form at both offset limits on the second pointer
    bus(1, 8'h10, 32'h0100);
    issue(SME_IND, 7'h00, 0, 1, 0, 1, 6'h20);
    `CHK("idx lo", 8'he0, w_out)
    issue(SME_IND, 7'h00, 0, 1, 0, 1, 6'h1f);
    `CHK("idx hi", 8'h1e, w_out)
    bus(0, 8'h10, 0);
    `CHK("idx ptr", 32'h0100, rd)
    bus(0, 8'h40, 0);
    `CHK("unmapped", 32'h0, rd)
    // Disabled core refuses instructions
    bus(1, 8'h00, 0);
    // Enable flop moves at the answer edge; look once it has settled
    @(negedge clk);
    `CHK("ready", 1'b0, cmd_ready)
    issue(SME_SHL, 7'h05, 0, 0, 0, 0, 0);
    `CHK("refused w", 8'h1e, w_out)
    bus(1, 8'h00, 1);
    @(negedge clk);
    `CHK("ready", 1'b1, cmd_ready)
    // Mid-run reset returns W, flags and pointers to their reset values
    @(posedge clk);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    @(negedge clk);
    `CHK("rst wcz", {8'h00, 2'b00}, {w_out, carry_out, zero_out})
    bus(0, 8'h10, 0);
    `CHK("rst ptr", 32'h0, rd)
    final_report();
  end
endmodule
